// File: logic/flash_host_ctrl.sv
// Purpose: Host controller that issues program, erase, suspend, resume and reset
//          sequences to a parallel NOR flash and polls its status bits.
// Assumes: Software reaches the control registers over Avalon-MM; flash pins are
//          synchronous to clk; ready_busy_in is the pulled-up wired pin level.
// Notes: Program, erase and resume end by the toggle-bit method, then one more read for data; suspend waits for the ready pin.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl
	import flash_host_pkg::*;
#(
	parameter logic [ADDR_W-1:0] UNLOCK_ADDR_A = 22'h000555,
	parameter logic [ADDR_W-1:0] UNLOCK_ADDR_B = 22'h0002aa,
	parameter logic [DATA_W-1:0] CMD_UNLOCK_A = 16'h00aa,
	parameter logic [DATA_W-1:0] CMD_UNLOCK_B = 16'h0055,
	parameter logic [DATA_W-1:0] CMD_PROGRAM = 16'h00a0,
	parameter logic [DATA_W-1:0] CMD_ERASE_SETUP = 16'h0080,
	parameter logic [DATA_W-1:0] CMD_SECTOR_ERASE = 16'h0030,
	parameter logic [DATA_W-1:0] CMD_CHIP_ERASE = 16'h0010,
	parameter logic [DATA_W-1:0] CMD_SUSPEND = 16'h00b0,
	parameter logic [DATA_W-1:0] CMD_RESUME = 16'h0030,
	parameter logic [DATA_W-1:0] CMD_RESET = 16'h00f0
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [REG_AW-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic [ADDR_W-1:0] flash_addr,
	output logic ce_b,
	output logic oe_b,
	output logic we_b,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe,
	input wire logic ready_busy_in
);
	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ISSUE = 3'b001,
		ST_POLL_A = 3'b010,
		ST_POLL_B = 3'b011,
		ST_FINAL = 3'b100,
		ST_WAIT_READY = 3'b101
	} seq_state_e;

	seq_state_e state;
	logic [2:0] op;
	logic [2:0] idx;
	logic [ADDR_W-1:0] cmd_addr;
	logic [DATA_W-1:0] cmd_wdata;
	logic [ADDR_W-1:0] erase_addr;
	logic [DATA_W-1:0] result;
	logic [7:0] first_byte;
	logic [7:0] last_byte;
	logic busy, done_flag, fail, suspended, refused, toggle2_seen;
	logic retried, pending_suspend, wait_cyc, cyc_start, cyc_wr;
	logic [ADDR_W-1:0] cyc_addr;
	logic [DATA_W-1:0] cyc_wdata;
	logic cyc_done;
	logic [DATA_W-1:0] cyc_rdata;

	// Address and data of write number i of a command sequence
	function automatic logic [ADDR_W+DATA_W-1:0] seq_word(input logic [2:0] o,
			input logic [2:0] i, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
		logic [ADDR_W+DATA_W-1:0] w;
		w = {UNLOCK_ADDR_A, CMD_RESET};
		case (i)
			3'h0: w = {UNLOCK_ADDR_A, CMD_UNLOCK_A};
			3'h1: w = {UNLOCK_ADDR_B, CMD_UNLOCK_B};
			3'h2: w = {UNLOCK_ADDR_A, (o == OP_PROGRAM) ? CMD_PROGRAM : CMD_ERASE_SETUP};
			3'h3: w = (o == OP_PROGRAM) ? {a, d} : {UNLOCK_ADDR_A, CMD_UNLOCK_A};
			3'h4: w = {UNLOCK_ADDR_B, CMD_UNLOCK_B};
			3'h5: w = (o == OP_SECTOR_ERASE) ? {a, CMD_SECTOR_ERASE} :
				{UNLOCK_ADDR_A, CMD_CHIP_ERASE};
			default: w = {UNLOCK_ADDR_A, CMD_RESET};
		endcase
		// Single-write commands use the address a and ignore the index
		if (o == OP_SUSPEND) w = {a, CMD_SUSPEND};
		if (o == OP_RESUME) w = {a, CMD_RESUME}; // see RULE1
		if (o == OP_RESET) w = {a, CMD_RESET};
		return w;
	endfunction

	// Register bus decode; an access is taken when waitrequest is low
	wire take_wr = avs_write && !avs_waitrequest;
	wire ctrl_wr = take_wr && (avs_address == REG_CTRL);
	wire [2:0] new_op = avs_writedata[2:0];
	wire is_erase = (new_op == OP_SECTOR_ERASE) || (new_op == OP_CHIP_ERASE);
	// No identification sequence exists here, and no erase starts while suspended
	wire idle_ok = (new_op == OP_READ) || (new_op == OP_PROGRAM) || (new_op == OP_RESET) ||
		(is_erase && !suspended) || ((new_op == OP_RESUME) && suspended); // see RULE2 RULE4
	wire start_ok = ctrl_wr && !busy && idle_ok;
	wire suspend_ok = ctrl_wr && busy && (new_op == OP_SUSPEND) &&
		(op == OP_SECTOR_ERASE) && !pending_suspend;
	wire [2:0] seq_len = (op == OP_PROGRAM) ? LEN_PROGRAM :
		((op == OP_SECTOR_ERASE) || (op == OP_CHIP_ERASE)) ? LEN_ERASE : LEN_SINGLE;
	wire [ADDR_W-1:0] poll_addr = (op == OP_SECTOR_ERASE) ? erase_addr : cmd_addr; // see RULE9
	wire [ADDR_W+DATA_W-1:0] step = seq_word(op, idx, poll_addr, cmd_wdata);
	wire [7:0] rd_byte = cyc_rdata[7:0];
	wire toggling = rd_byte[TOGGLE1_POS] != first_byte[TOGGLE1_POS]; // see RULE13 RULE20
	wire [31:0] status_word = {16'h0000, last_byte, 1'b0, toggle2_seen, refused,
		ready_busy_in, suspended, fail, done_flag, busy};
	wire [31:0] read_mux = (avs_address == REG_ADDR) ? {10'h000, cmd_addr} :
		(avs_address == REG_WDATA) ? {16'h0000, cmd_wdata} :
		(avs_address == REG_STATUS) ? status_word :
		(avs_address == REG_RDATA) ? {16'h0000, result} : 32'h00000000;

	// Each access waits one cycle, then is taken
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			avs_waitrequest <= 1'b1;
			avs_readdata <= 32'h00000000;
		end else begin
			avs_waitrequest <= !((avs_read || avs_write) && avs_waitrequest);
			if (avs_read && avs_waitrequest) begin
				avs_readdata <= read_mux;
			end
		end
	end

	// Software-written order registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			cmd_addr <= 22'h000000;
			cmd_wdata <= 16'h0000;
		end else begin
			if (take_wr && (avs_address == REG_ADDR)) cmd_addr <= avs_writedata[ADDR_W-1:0];
			if (take_wr && (avs_address == REG_WDATA)) cmd_wdata <= avs_writedata[DATA_W-1:0];
		end
	end

	// Refused flag; a new taken order clears it, a refusal in that cycle wins
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			refused <= 1'b0;
		end else if (ctrl_wr) begin
			refused <= !(start_ok || suspend_ok);
		end
	end

	// Sequencer: command writes, toggle polling, final data read
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= ST_IDLE;
			op <= OP_NONE;
			idx <= 3'h0;
			erase_addr <= 22'h000000;
			result <= 16'h0000;
			first_byte <= 8'h00;
			last_byte <= 8'h00;
			busy <= 1'b0;
			done_flag <= 1'b0;
			fail <= 1'b0;
			suspended <= 1'b0;
			toggle2_seen <= 1'b0;
			retried <= 1'b0;
			pending_suspend <= 1'b0;
			wait_cyc <= 1'b0;
			cyc_start <= 1'b0;
			cyc_wr <= 1'b0;
			cyc_addr <= 22'h000000;
			cyc_wdata <= 16'h0000;
		end else begin
			cyc_start <= 1'b0;
			if (suspend_ok) pending_suspend <= 1'b1;
			case (state)
				ST_IDLE: begin
					if (start_ok) begin
						op <= new_op;
						idx <= 3'h0;
						busy <= 1'b1;
						done_flag <= 1'b0;
						fail <= 1'b0;
						retried <= 1'b0;
						toggle2_seen <= 1'b0;
						// A suspend left over from an erase that ended first must not hit the next one
						pending_suspend <= 1'b0;
						if (new_op == OP_SECTOR_ERASE) erase_addr <= cmd_addr;
						state <= (new_op == OP_READ) ? ST_FINAL : ST_ISSUE;
					end
				end
				ST_ISSUE: begin
					if (!wait_cyc) begin
						cyc_start <= 1'b1;
						cyc_wr <= 1'b1;
						{cyc_addr, cyc_wdata} <= step;
						wait_cyc <= 1'b1;
					end else if (cyc_done) begin
						wait_cyc <= 1'b0;
						idx <= idx + 3'h1;
						if (idx == seq_len - 3'h1) begin
							idx <= 3'h0;
							retried <= 1'b0;
							// Status is valid right after the last write
							case (op)
								OP_PROGRAM, OP_SECTOR_ERASE, OP_CHIP_ERASE: begin
									state <= ST_POLL_A; // see RULE6 RULE8 RULE14
								end
								OP_SUSPEND: state <= ST_WAIT_READY;
								OP_RESUME: begin
									op <= OP_SECTOR_ERASE;
									suspended <= 1'b0;
									state <= ST_POLL_A; // see RULE2
								end
								default: begin
									busy <= 1'b0;
									done_flag <= 1'b1;
									state <= ST_IDLE;
								end
							endcase
						end
					end
				end
				ST_POLL_A, ST_POLL_B: begin
					if (!wait_cyc && pending_suspend && (state == ST_POLL_A)) begin
						pending_suspend <= 1'b0;
						op <= OP_SUSPEND;
						idx <= 3'h0;
						state <= ST_ISSUE;
					end else if (!wait_cyc) begin
						cyc_start <= 1'b1;
						cyc_wr <= 1'b0;
						cyc_addr <= poll_addr;
						wait_cyc <= 1'b1;
					end else if (cyc_done) begin
						wait_cyc <= 1'b0;
						last_byte <= rd_byte;
						if (state == ST_POLL_A) begin
							first_byte <= rd_byte;
							state <= ST_POLL_B;
						end else begin
							if (rd_byte[TOGGLE2_POS] != first_byte[TOGGLE2_POS]) begin
								toggle2_seen <= 1'b1; // see RULE19
							end
							if (!toggling) begin
								state <= ST_FINAL; // see RULE20
							end else if (retried) begin
								// Still toggling after the timeout recheck: fail and reset
								fail <= 1'b1; // see RULE17 RULE21
								op <= OP_RESET;
								idx <= 3'h0;
								state <= ST_ISSUE;
							end else begin
								if (rd_byte[TIMEOUT_POS]) retried <= 1'b1; // see RULE16 RULE21
								state <= ST_POLL_A;
							end
						end
					end
				end
				ST_FINAL: begin
					// Fresh read, since the low lines may lag the poll bit
					if (!wait_cyc) begin
						cyc_start <= 1'b1;
						cyc_wr <= 1'b0;
						cyc_addr <= poll_addr;
						wait_cyc <= 1'b1;
					end else if (cyc_done) begin
						wait_cyc <= 1'b0;
						result <= cyc_rdata; // see RULE10
						busy <= 1'b0;
						done_flag <= 1'b1;
						state <= ST_IDLE;
					end
				end
				ST_WAIT_READY: begin
					// Pin goes high once the erase is suspended
					if (ready_busy_in) begin
						suspended <= 1'b1; // see RULE11 RULE22
						busy <= 1'b0;
						done_flag <= 1'b1;
						state <= ST_IDLE;
					end
				end
				default: begin
					state <= ST_IDLE;
				end
			endcase
		end
	end

	flash_bus_cycle u_cycle (
		.clk(clk),
		.rst_b(rst_b),
		.start(cyc_start),
		.wr(cyc_wr),
		.addr_in(cyc_addr),
		.wdata(cyc_wdata),
		.done(cyc_done),
		.rdata(cyc_rdata),
		.flash_addr(flash_addr),
		.ce_b(ce_b),
		.oe_b(oe_b),
		.we_b(we_b),
		.dq_in(dq_in),
		.dq_out(dq_out),
		.dq_oe(dq_oe)
	);
endmodule
`default_nettype wire

// File: inc/flash_host_pkg.sv
// Purpose: Shared constants for the flash status-polling host controller.
// Assumes: 250 MHz clock; the flash is a parallel NOR part with 22 address and 16 data lines.
// Notes: Status bit positions refer to the low byte the flash returns while an
//        embedded algorithm runs.
// Notes on behaviour
// RULE1: Resume is a single write of the resume code; any address will do.
// RULE2: Repeated resumes are ignored by the flash; a new suspend may follow resume.
// RULE3: Reads inside a suspended sector return status on all eight low lines.
// RULE4: Identification command sequences are not accepted while erase is suspended.
// RULE5: During programming the poll bit reads inverted bit 7; afterwards the true bit.
// RULE6: Poll bit is valid from the rising edge of the fourth program write.
// RULE7: Poll bit reads 0 while erasing and 1 once erase completes.
// RULE8: For erase, poll bit is valid from the last write of six cycles.
// RULE9: Host polls inside the unprotected sector being programmed or erased.
// RULE10: Poll bit may flip before other lines settle; host re-reads for valid data.
// RULE11: Ready/busy pin is low while programming or erasing, high when readable.
// RULE12: Ready/busy reflects the algorithm from the final command write onward.
// RULE13: Toggle bit one inverts on each read while busy, then stops.
// RULE14: Toggle bit one valid after fourth write (program) or sixth write (erase).
// RULE15: Protected targets toggle briefly (about 2 or 100 us) then stop unchanged.
// RULE16: Timeout error bit reads 1 when the internal pulse-count limit is exceeded.
// RULE17: Programming one over zero ends in timeout error; host then writes reset.
// RULE18: Erase timer bit goes 1 when sector erase starts; not for chip erase.
// RULE19: Toggle bit two toggles on reads of erase-selected sectors, active or suspended.
// RULE20: Host reads status twice in a row; equal toggle bits mean finished.
// RULE21: Toggling with timeout bit high: check once more; still toggling means failure, reset.
// RULE22: Suspended sector reads: poll 1, toggle one steady, toggle two toggling, ready high.
package flash_host_pkg;
	localparam int CLK_PERIOD_PS = 4000;
	localparam int T_WP_NS = 30;
	localparam int T_WPH_NS = 25;
	localparam int T_ACC_NS = 90;
	localparam int T_DF_NS = 20;
	// Least times round up to whole cycles
	localparam int WP_CYCLES = (T_WP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int WPH_CYCLES = (T_WPH_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int ACC_CYCLES = (T_ACC_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
	localparam int DF_CYCLES = (T_DF_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// Register byte offsets on the Avalon slave
	localparam int REG_AW = 5;
	localparam logic [4:0] REG_CTRL = 5'h00;
	localparam logic [4:0] REG_ADDR = 5'h04;
	localparam logic [4:0] REG_WDATA = 5'h08;
	localparam logic [4:0] REG_STATUS = 5'h0c;
	localparam logic [4:0] REG_RDATA = 5'h10;

	// Operation codes written to the control register
	localparam logic [2:0] OP_NONE = 3'h0;
	localparam logic [2:0] OP_READ = 3'h1;
	localparam logic [2:0] OP_PROGRAM = 3'h2;
	localparam logic [2:0] OP_SECTOR_ERASE = 3'h3;
	localparam logic [2:0] OP_CHIP_ERASE = 3'h4;
	localparam logic [2:0] OP_SUSPEND = 3'h5;
	localparam logic [2:0] OP_RESUME = 3'h6;
	localparam logic [2:0] OP_RESET = 3'h7;

	// Command sequence lengths in write cycles
	localparam logic [2:0] LEN_PROGRAM = 3'h4;
	localparam logic [2:0] LEN_ERASE = 3'h6;
	localparam logic [2:0] LEN_SINGLE = 3'h1;

	// Bit positions in the flash status byte
	localparam int POLL_POS = 7;
	localparam int TOGGLE1_POS = 6;
	localparam int TIMEOUT_POS = 5;
	localparam int ERASE_TIMER_POS = 3;
	localparam int TOGGLE2_POS = 2;

	// Bit positions in the controller status register
	localparam int STS_BUSY = 0;
	localparam int STS_DONE = 1;
	localparam int STS_FAIL = 2;
	localparam int STS_SUSPENDED = 3;
	localparam int STS_READY_PIN = 4;
	localparam int STS_REFUSED = 5;
	localparam int STS_TOGGLE2_SEEN = 6;
	localparam int STS_BYTE_LSB = 8;
	localparam int STS_BYTE_MSB = 15;
endpackage

// File: logic/flash_bus_cycle.sv
// Purpose: One asynchronous flash bus cycle (read or write) timed in clock cycles.
// Assumes: Pin inputs are synchronous to clk; one cycle at a time.
// Notes: Chip select and the strobe both return high after every cycle so each
//        read counts as a fresh access for the toggle bits.
`timescale 1ns/1ps
`default_nettype none
module flash_bus_cycle
	import flash_host_pkg::*;
#(
	parameter int STROBE_WR = WP_CYCLES,
	parameter int RECOVER_WR = WPH_CYCLES,
	parameter int STROBE_RD = ACC_CYCLES,
	parameter int RECOVER_RD = DF_CYCLES
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic start,
	input wire logic wr,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata,
	output logic done,
	output logic [DATA_W-1:0] rdata,
	output logic [ADDR_W-1:0] flash_addr,
	output logic ce_b,
	output logic oe_b,
	output logic we_b,
	input wire logic [DATA_W-1:0] dq_in,
	output logic [DATA_W-1:0] dq_out,
	output logic dq_oe
);
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_SETUP = 2'b01,
		PH_STROBE = 2'b10,
		PH_RECOVER = 2'b11
	} phase_e;

	phase_e phase;
	logic [5:0] cnt;
	logic is_wr;

	// Strobe and recovery lengths for the current direction
	wire [5:0] strobe_len = is_wr ? 6'(STROBE_WR - 1) : 6'(STROBE_RD - 1);
	wire [5:0] recover_len = is_wr ? 6'(RECOVER_WR - 1) : 6'(RECOVER_RD - 1);

	// Phase sequencer; read data sampled at the end of the access time
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			phase <= PH_IDLE;
			cnt <= 6'h00;
			is_wr <= 1'b0;
			done <= 1'b0;
			rdata <= 16'h0000;
			flash_addr <= 22'h000000;
			ce_b <= 1'b1;
			oe_b <= 1'b1;
			we_b <= 1'b1;
			dq_out <= 16'h0000;
			dq_oe <= 1'b0;
		end else begin
			done <= 1'b0;
			case (phase)
				PH_IDLE: begin
					if (start) begin
						flash_addr <= addr_in;
						dq_out <= wdata;
						dq_oe <= wr;
						is_wr <= wr;
						ce_b <= 1'b0;
						phase <= PH_SETUP;
					end
				end
				PH_SETUP: begin
					we_b <= ~is_wr;
					oe_b <= is_wr;
					cnt <= strobe_len;
					phase <= PH_STROBE;
				end
				PH_STROBE: begin
					if (cnt == 6'h00) begin
						if (!is_wr) begin
							rdata <= dq_in;
						end
						we_b <= 1'b1; // Rising edge latches the command
						oe_b <= 1'b1;
						cnt <= recover_len;
						phase <= PH_RECOVER;
					end else begin
						cnt <= cnt - 6'h01;
					end
				end
				PH_RECOVER: begin
					// Recovery also covers the flash releasing the data lines
					if (cnt == 6'h00) begin
						ce_b <= 1'b1;
						dq_oe <= 1'b0;
						done <= 1'b1;
						phase <= PH_IDLE;
					end else begin
						cnt <= cnt - 6'h01;
					end
				end
				default: begin
					phase <= PH_IDLE;
				end
			endcase
		end
	end
endmodule
`default_nettype wire

// File: sim/flash_host_ctrl_sva.sv
// Purpose: Pin-level checks on the flash host controller.
// Assumes: One clock domain, asynchronous active-low reset.
// Notes: Sees only the controller's ports; bound below.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_sva
	import flash_host_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic ce_b,
	input wire logic oe_b,
	input wire logic we_b,
	input wire logic [DATA_W-1:0] dq_out,
	input wire logic dq_oe
);
	logic [7:0] rd_len;

	// Length of the running read strobe, judged when it ends
	always_ff @(posedge clk or negedge rst_b)
		if (!rst_b)
			rd_len <= 8'h00;
		else
			rd_len <= oe_b ? 8'h00 : rd_len + 8'h01;

	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);

	ans_once_a: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus answer not one cycle after request");
	wait_pulse_a: assert property (!avs_waitrequest |=> avs_waitrequest)
		else $error("waitrequest low longer than one cycle");
	strobe_excl_a: assert property (!(oe_b == 1'b0 && we_b == 1'b0))
		else $error("read and write strobes low together");
	wr_pulse_a: assert property ($fell(we_b) |-> !we_b [*8] ##1 we_b)
		else $error("write strobe not eight cycles");
	wr_data_a: assert property (!we_b |-> dq_oe && !ce_b && $stable(dq_out))
		else $error("write data not held under strobe");
	rd_len_a: assert property ($rose(oe_b) |-> rd_len == 8'h17)
		else $error("read strobe not 23 cycles");
	sel_gate_a: assert property (ce_b |-> oe_b && we_b && !dq_oe)
		else $error("strobe or drive without chip select");
	rd_nodrive_a: assert property (!oe_b |-> !dq_oe)
		else $error("host drives lines during a read");

	wr_seen_c: cover property ($fell(we_b));
	rd_seen_c: cover property ($rose(oe_b));
	bus_wr_c: cover property (avs_write && !avs_waitrequest);
endmodule
bind flash_host_ctrl flash_host_ctrl_sva chk (
	.clk(clk), .rst_b(rst_b), .avs_read(avs_read), .avs_write(avs_write),
	.avs_waitrequest(avs_waitrequest), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b),
	.dq_out(dq_out), .dq_oe(dq_oe)
);
`default_nettype wire

// File: sim/flash_model.sv
// Purpose: Behavioural flash device answering the controller.
// Assumes: Pins move on clk edges; busy times counted in clk cycles.
// Notes: Lagging low lines are not modelled; a protected program leaves the word unchanged; erase clears the whole array.
`timescale 1ns/1ps
`default_nettype none
module flash_model
	import flash_host_pkg::*;
#(
	parameter int PROG_CYCLES = 300,
	parameter int ERASE_CYCLES = 3000,
	parameter logic [6:0] PROT_SEC = 7'h7f
) (
	input wire logic clk,
	input wire logic [ADDR_W-1:0] flash_addr,
	input wire logic ce_b,
	input wire logic oe_b,
	input wire logic we_b,
	input wire logic [DATA_W-1:0] dq_host,
	output logic [DATA_W-1:0] dq_dev,
	output logic ready_busy_low
);
	typedef enum logic [2:0] {IDLE, PROG, ERASE, SUSP, FAULT} mode_e;
	mode_e mode = IDLE;
	logic [DATA_W-1:0] mem [0:255];
	logic [DATA_W-1:0] pdata = 16'h0000;
	logic [DATA_W-1:0] last = 16'h0000;
	logic [ADDR_W-1:0] pa = 22'h000000;
	logic tog = 1'b0;
	logic tog2 = 1'b0;
	logic chip = 1'b0;
	logic prot = 1'b0;
	logic we_q = 1'b1;
	logic oe_q = 1'b1;
	logic [7:0] st;
	wire in_sec;
	wire status_on;
	int step = 0;
	int left = 0;

	initial for (int i = 0; i < 256; i++) mem[i] = 16'hffff;

	// Status byte for each mode
	always_comb
		case (mode)
			PROG: st = {~pdata[7], tog, 6'h00};
			ERASE: st = {1'b0, tog, 2'h0, ~chip, tog2, 2'h0};
			SUSP: st = {1'b1, tog, 3'h0, tog2, 2'h0};
			FAULT: st = {~pdata[7], tog, 1'b1, 5'h00};
			default: st = 8'h00;
		endcase

	// Released lines show the inverse so a stale value never passes
	assign in_sec = chip || flash_addr[ADDR_W-1:15] == pa[ADDR_W-1:15];
	assign status_on = mode != IDLE && !(mode == SUSP && !in_sec);
	assign dq_dev = (!ce_b && !oe_b) ? (status_on ? {8'h00, st} : mem[flash_addr[7:0]]) : ~last;
	assign ready_busy_low = mode == PROG || mode == ERASE || mode == FAULT;

	// Toggles on each read end, timers, command decode on write strobe rise
	always @(posedge clk) begin
		we_q <= we_b;
		oe_q <= oe_b;
		if (!ce_b && !oe_b)
			last <= dq_dev;
		if (oe_b && !oe_q && !ce_b) begin
			tog <= ready_busy_low ? ~tog : tog;
			tog2 <= ((mode == ERASE || mode == SUSP) && in_sec) ? ~tog2 : tog2;
		end
		if ((mode == PROG || mode == ERASE) && left > 0)
			left <= left - 1;
		else if (mode == PROG) begin
			if (!prot)
				mem[pa[7:0]] <= pdata;
			mode <= IDLE;
		end else if (mode == ERASE) begin
			for (int i = 0; i < 256; i++)
				mem[i] <= 16'hffff;
			mode <= IDLE;
		end
		if (we_b && !we_q && !ce_b) begin
			if (dq_host[7:0] == 8'hf0 && mode != PROG && mode != ERASE) begin
				mode <= IDLE;
				step = 0;
			end else if (mode == ERASE && !chip && dq_host[7:0] == 8'hb0)
				mode <= SUSP;
			else if (mode == SUSP && step == 0 && dq_host[7:0] == 8'h30)
				mode <= ERASE;
			else if (mode == IDLE || mode == SUSP)
				case (step)
					0, 3: step = (dq_host[7:0] == 8'haa) ? step + 1 : 0;
					1, 4: step = (dq_host[7:0] == 8'h55) ? step + 1 : 0;
					2: step = (dq_host[7:0] == 8'ha0) ? 6 : (dq_host[7:0] == 8'h80 && mode == IDLE) ? 3 : 0;
					5: begin
						chip <= dq_host[7:0] == 8'h10;
						pa <= flash_addr;
						left <= ERASE_CYCLES;
						mode <= (dq_host[7:0] == 8'h30 || dq_host[7:0] == 8'h10) ? ERASE : IDLE;
						step = 0;
					end
					default: begin
						pa <= flash_addr;
						pdata <= dq_host;
						prot <= flash_addr[ADDR_W-1:15] == PROT_SEC;
						left <= PROG_CYCLES;
						mode <= |(dq_host & ~mem[flash_addr[7:0]]) ? FAULT : PROG;
						step = 0;
					end
				endcase
		end
	end
endmodule
`default_nettype wire

// File: sim/flash_host_ctrl_tb.sv
// Purpose: Self-checking bench for the flash host controller.
// Assumes: Flash model on the pins; ready pin pulled up.
// Notes: Scenarios run in order and share the flash contents.
`timescale 1ns/1ps
`default_nettype none
module flash_host_ctrl_tb
	import flash_host_pkg::*;
	;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic [REG_AW-1:0] avs_address = 5'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [ADDR_W-1:0] flash_addr;
	logic ce_b, oe_b, we_b, dq_oe, rb_low;
	logic [DATA_W-1:0] dq_in, dq_out, dq_dev;
	logic [31:0] rd;
	int errors = 0;
	int n_compared = 0;

	always #2 clk = ~clk;
	// Shared data lines: host drive wins while enabled
	assign dq_in = dq_oe ? dq_out : dq_dev;

	flash_host_ctrl dut (.clk(clk), .rst_b(rst_b), .avs_address(avs_address),
		.avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
		.flash_addr(flash_addr), .ce_b(ce_b), .oe_b(oe_b), .we_b(we_b), .dq_in(dq_in),
		.dq_out(dq_out), .dq_oe(dq_oe), .ready_busy_in(!rb_low));
	flash_model fm (.clk(clk), .flash_addr(flash_addr), .ce_b(ce_b), .oe_b(oe_b),
		.we_b(we_b), .dq_host(dq_out), .dq_dev(dq_dev), .ready_busy_low(rb_low));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			errors++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// One Avalon access, held until waitrequest is sampled low
	task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
		@(posedge clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		@(posedge clk);
		while (avs_waitrequest)
			@(posedge clk);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask

	task automatic run(input logic [2:0] op);
		bus(1'b1, REG_CTRL, {29'h0, op});
		bus(1'b0, REG_STATUS, 32'h0);
		while (rd[STS_BUSY])
			bus(1'b0, REG_STATUS, 32'h0);
	endtask

	task automatic refused(input logic [2:0] op);
		bus(1'b1, REG_CTRL, {29'h0, op});
		bus(1'b0, REG_STATUS, 32'h0);
		check({31'h0, rd[STS_REFUSED]}, 32'h1);
	endtask

	task automatic t_regs;
		bus(1'b1, 5'h14, 32'hffffffff);
		bus(1'b0, 5'h14, 32'h0);
		check(rd, 32'h0);
		bus(1'b0, REG_STATUS, 32'h0);
		check(rd & 32'h3f, 32'h10);
		refused(OP_SUSPEND);
		refused(OP_RESUME);
		refused(OP_NONE);
		run(OP_RESET);
		check(rd & 32'h3f, 32'h12);
	endtask

	task automatic t_program(input logic [21:0] a, input logic [15:0] d, input logic bad);
		bus(1'b1, REG_ADDR, {10'h0, a});
		bus(1'b1, REG_WDATA, {16'h0, d});
		run(OP_PROGRAM);
		check({29'h0, rd[2:0]}, {29'h0, bad, 2'b10});
		if (!bad) begin
			check({24'h0, rd[15:8]}, {24'h0, d[7:0]});
			bus(1'b0, REG_RDATA, 32'h0);
			check(rd, {16'h0, d});
		end
	endtask

	task automatic t_read(input logic [21:0] a, input logic [15:0] d);
		bus(1'b1, REG_ADDR, {10'h0, a});
		run(OP_READ);
		bus(1'b0, REG_RDATA, 32'h0);
		check(rd, {16'h0, d});
	endtask

	// Sector erase, suspend in mid-run, refused erase, resume, repeat resume
	task automatic t_suspend;
		bus(1'b1, REG_ADDR, 32'h0000_8040);
		bus(1'b1, REG_CTRL, {29'h0, OP_SECTOR_ERASE});
		repeat (100) bus(1'b0, REG_STATUS, 32'h0);
		check({24'h0, rd[15:8] & 8'h89}, 32'h08);
		run(OP_SUSPEND);
		check(rd & 32'h3f, 32'h1a);
		refused(OP_CHIP_ERASE);
		// Read inside the suspended sector gives status, not array data
		run(OP_READ);
		bus(1'b0, REG_RDATA, 32'h0);
		check(rd & 32'hffffffbb, 32'h80);
		run(OP_RESUME);
		check(rd & 32'h47, 32'h42);
		bus(1'b0, REG_RDATA, 32'h0);
		check(rd, 32'h0000ffff);
		refused(OP_RESUME);
	endtask

	task automatic t_chip;
		bus(1'b1, REG_ADDR, 32'h0000_0040);
		run(OP_CHIP_ERASE);
		check({29'h0, rd[2:0]}, 32'h2);
		t_read(22'h000040, 16'hffff);
	endtask

	// Program into the protected sector: it toggles, then leaves the word as it was
	task automatic t_protect;
		bus(1'b1, REG_ADDR, 32'h003f_8041);
		bus(1'b1, REG_WDATA, 32'h0);
		run(OP_PROGRAM);
		check({29'h0, rd[2:0]}, 32'h2);
		bus(1'b0, REG_RDATA, 32'h0);
		check(rd, 32'h0000ffff);
	endtask

	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", n_compared, errors);
		if (errors == 0 && n_compared > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	// Watchdog well beyond the expected run length
	initial begin
		#320000;
		errors++;
		final_report();
	end

	initial begin
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		t_regs();
		t_program(22'h000040, 16'h1234, 1'b0);
		t_program(22'h000040, 16'h00ff, 1'b1);
		t_read(22'h000040, 16'h1234);
		t_suspend();
		t_program(22'h000040, 16'h1234, 1'b0);
		t_chip();
		t_protect();
		final_report();
	end
endmodule
`default_nettype wire
